// ==== logic/mcr_log_if.sv ====
`timescale 1ns/1ps
// carries a captured code to the logout writer and its storage stream back
interface mcr_log_if;
  logic        start;
  logic [0:63] code;
  logic [15:0] faddr;
  logic        busy;
  logic        done;
  logic        st_we;
  logic [8:0]  st_addr;
  logic [7:0]  st_data;
  modport ctrl (output start, output code, output faddr,
                input busy, input done, input st_we, input st_addr, input st_data);
  modport writer (input start, input code, input faddr,
                  output busy, output done, output st_we, output st_addr, output st_data);
endinterface : mcr_log_if

// ==== logic/mcr_logout.sv ====
`timescale 1ns/1ps
// writes the code bytes and the failing address into the fixed logout area
module mcr_logout
  import mcr_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control side
  mcr_log_if.writer lg
);
  localparam logic [3:0] LAST_IDX = 4'(CODE_BYTES + FADDR_BYTES - 1);

  mcr_log_state_t state_reg;
  logic [3:0]     idx_reg;
  logic [0:63]    code_reg;
  logic [15:0]    faddr_reg;

  assign lg.busy = (state_reg == MCR_LOG_WRITE);

  // one byte per cycle: code first, then the address halfword
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= MCR_LOG_IDLE;
      idx_reg    <= '0;
      code_reg   <= '0;
      faddr_reg  <= '0;
      lg.st_we   <= 1'b0;
      lg.st_addr <= '0;
      lg.st_data <= '0;
      lg.done    <= 1'b0;
    end else begin
      lg.st_we <= 1'b0;
      lg.done  <= 1'b0;
      case (state_reg)
        MCR_LOG_IDLE: begin
          if (lg.start) begin
            code_reg  <= lg.code;
            faddr_reg <= lg.faddr;
            idx_reg   <= '0;
            state_reg <= MCR_LOG_WRITE;
          end
        end
        MCR_LOG_WRITE: begin
          lg.st_we <= 1'b1;
          if (idx_reg < 4'(CODE_BYTES)) begin
            lg.st_addr <= LOG_CODE_ADDR + 9'(idx_reg);
            lg.st_data <= code_reg[8*idx_reg +: 8];
          end else begin
            lg.st_addr <= LOG_FADDR_ADDR + 9'(idx_reg - 4'(CODE_BYTES));
            lg.st_data <= (idx_reg == 4'(CODE_BYTES)) ? faddr_reg[15:8] : faddr_reg[7:0];
          end
          if (idx_reg == LAST_IDX) begin
            state_reg <= MCR_LOG_IDLE;
            lg.done   <= 1'b1;
          end else begin
            idx_reg <= idx_reg + 4'h1;
          end
        end
        default: state_reg <= MCR_LOG_IDLE;
      endcase
    end
  end
endmodule : mcr_logout

// ==== logic/mcr_machine_check.sv ====
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
// Operation
// - code logged to storage bytes 232-239
// - bit 0 reports system damage
// - bit 1 reports instruction processing damage
// - bit 2 recovery; bits 3,4 together
// - bits 20-23 mark old status fields valid
// - bit 24 marks failing address valid
// - bits 27-29,46,47 mark saved state valid
// - bit 31 marks operand storage valid
// - mask bit 13 clear holds off all
// - recovery and external submasks need bit 13
// - exigent types need only bit 13
// - diskette logging ignores the masks
// - timer/recovery repressible; damage types exigent
// - timing damage needs external submask
// - timing damage from any timing facility
// - damaged timer access adds processing damage
// - recovery report after successful retry
// - processing damage on unretryable or failed retry
// - key fails give 2K block address
// - system damage for non-isolated failures
module mcr_machine_check
  import mcr_pkg::*;
(
  // clock and reset
  input  wire logic               CLK_SYS,
  input  wire logic               RST_B,
  // wishbone slave
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [7:0]         WB_ADR_I,
  input  wire logic [31:0]        WB_DAT_I,
  input  wire logic [3:0]         WB_SEL_I,
  output logic      [31:0]        WB_DAT_O,
  output logic                    WB_ACK_O,
  // malfunction events, one-cycle pulses
  input  wire logic               ERR_SYSTEM,
  input  wire logic               ERR_INTR_FAIL,
  input  wire logic               ERR_CREG_DAMAGE,
  input  wire logic               ERR_UNRETRYABLE,
  input  wire logic               ERR_RETRY_OK,
  input  wire logic               ERR_RETRY_FAIL,
  input  wire logic               ERR_TOD_CLOCK,
  input  wire logic               ERR_INTERVAL_TMR,
  input  wire logic               ERR_CPU_TIMER,
  input  wire logic               ERR_CLK_CMP,
  input  wire logic               ERR_TIMER_ACCESS,
  input  wire logic               ERR_KEY_FAIL,
  input  wire logic               ERR_STOR_MULTI,
  input  wire logic [15:0]        ERR_ADDR,
  // validity of saved state, level
  input  wire logic [VIN_W-1:0]   SAVE_VALID,
  // interruption sequencer
  input  wire logic               MC_TAKE,
  output logic                    MC_REQ,
  output logic                    MC_DONE,
  // storage logout port
  output logic                    ST_WE,
  output logic [8:0]              ST_ADDR,
  output logic [7:0]              ST_DATA,
  // service logging
  input  wire logic               DISK_LOG_EN,
  output logic                    DISK_LOG
);
  //////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisation
  logic rst_meta_reg;
  logic rst_n;
  logic disk_en;

  // assert at once, release after two clean edges
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // operator setting arrives from a panel pin
  mcr_sync #(.WIDTH(1)) u_disk_sync (
    .clk   (CLK_SYS),
    .rst_n (rst_n),
    .d     (DISK_LOG_EN),
    .q     (disk_en)
  );

  //////////////////////////////////////////////////////////////////////////////
  // control and wishbone slave
  logic [2:0]  ctrl_reg;
  logic        wb_req;
  logic [0:63] last_code_reg;
  logic [15:0] last_faddr_reg;
  logic [3:0]  pend_vec;
  logic        busy;

  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  // ack one cycle after the request, dropped the next cycle
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req;
    end
  end

  // mask bits; only byte lane 0 carries them
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == REG_CTRL) begin
      ctrl_reg <= WB_DAT_I[2:0];
    end
  end

  // read data; unmapped offsets read zero, writes to them are dropped
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      WB_DAT_O <= '0;
    end else if (wb_req && !WB_WE_I) begin
      case (WB_ADR_I)
        REG_CTRL:    WB_DAT_O <= {29'h0, ctrl_reg};
        REG_STATUS:  WB_DAT_O <= {26'h0, MC_REQ, busy, pend_vec};
        REG_CODE_HI: WB_DAT_O <= last_code_reg[0:31];
        REG_CODE_LO: WB_DAT_O <= last_code_reg[32:63];
        REG_FADDR:   WB_DAT_O <= {16'h0, last_faddr_reg};
        default:     WB_DAT_O <= 32'h0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event classification
  logic sd_set;
  logic pd_set;
  logic sr_set;
  logic td_set;
  logic fa_set;

  assign sd_set = ERR_SYSTEM || ERR_INTR_FAIL || ERR_CREG_DAMAGE;
  // unretryable, failed retry, damaged timer access
  assign pd_set = ERR_UNRETRYABLE || ERR_RETRY_FAIL || ERR_TIMER_ACCESS;
  assign sr_set = ERR_RETRY_OK;
  assign td_set = ERR_TOD_CLOCK || ERR_INTERVAL_TMR || ERR_CPU_TIMER || ERR_CLK_CMP
                  || ERR_TIMER_ACCESS;
  assign fa_set = ERR_KEY_FAIL || ERR_STOR_MULTI;

  //////////////////////////////////////////////////////////////////////////////
  // pending conditions
  logic system_damage_flag;
  logic processing_damage_flag;
  logic recovery_report_flag;
  logic timer_damage_flag;
  logic key_error_uncorrected_flag;
  logic storage_error_uncorrected_flag;
  logic fa_valid_reg;
  logic [15:0] faddr_reg;
  logic        take;
  logic [3:0]  rep_vec;

  assign pend_vec = {timer_damage_flag, recovery_report_flag,
                     processing_damage_flag, system_damage_flag};

  // system damage: clear only when reported; a new event in the same cycle wins
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      system_damage_flag <= 1'b0;
    end else begin
      system_damage_flag <= sd_set || (system_damage_flag && !(take && rep_vec[0]));
    end
  end

  // processing damage: a masked report stays pending for a later take
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      processing_damage_flag <= 1'b0;
    end else begin
      processing_damage_flag <= pd_set || (processing_damage_flag && !(take && rep_vec[1]));
    end
  end

  // recovery report: waits on its submask without losing the event
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      recovery_report_flag <= 1'b0;
    end else begin
      recovery_report_flag <= sr_set || (recovery_report_flag && !(take && rep_vec[2]));
    end
  end

  // timer damage: one flag feeds both code bits, so they cannot part
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      timer_damage_flag <= 1'b0;
    end else begin
      timer_damage_flag <= td_set || (timer_damage_flag && !(take && rep_vec[3]));
    end
  end

  // storage error kind and failing address, held until reported
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      key_error_uncorrected_flag     <= 1'b0;
      storage_error_uncorrected_flag <= 1'b0;
      fa_valid_reg                   <= 1'b0;
      faddr_reg                      <= '0;
    end else if (fa_set) begin
      key_error_uncorrected_flag     <= ERR_KEY_FAIL;
      storage_error_uncorrected_flag <= ERR_STOR_MULTI;
      fa_valid_reg                   <= 1'b1;
      // key fault names its 2K block
      if (ERR_KEY_FAIL) begin
        faddr_reg <= {ERR_ADDR[15:KEY_BLOCK_LSB], KEY_BLOCK_LSB'(0)};
      end else begin
        faddr_reg <= ERR_ADDR;
      end
    end else if (take && rep_vec[1]) begin
      key_error_uncorrected_flag     <= 1'b0;
      storage_error_uncorrected_flag <= 1'b0;
      fa_valid_reg                   <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // masking
  logic mchk_en;
  logic recov_en;
  logic ext_en;
  logic exigent;
  logic repressible;

  // bit 13 clear holds everything off
  assign mchk_en = ctrl_reg[CTRL_MCHK_MASK];
  // submasks count only with bit 13
  assign recov_en = mchk_en && ctrl_reg[CTRL_RECOV_MASK];
  assign ext_en = mchk_en && ctrl_reg[CTRL_EXT_MASK];
  // exigent types need only bit 13
  assign exigent = system_damage_flag || processing_damage_flag;
  assign repressible = (recovery_report_flag && recov_en) || (timer_damage_flag && ext_en);

  assign rep_vec = {timer_damage_flag && ext_en, recovery_report_flag && recov_en,
                    processing_damage_flag && mchk_en, system_damage_flag && mchk_en};

  // no new interruption until the previous logout is out
  assign take = MC_TAKE && MC_REQ && !busy;

  // request to the sequencer
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      MC_REQ <= 1'b0;
    end else begin
      MC_REQ <= ((mchk_en && exigent) || repressible) && !busy && !take;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // machine-check code assembly
  logic [0:63] code;

  always_comb begin
    // everything not set below is zero
    code = '0;
    code[BIT_SYS_DAMAGE]   = rep_vec[0];
    code[BIT_PROC_DAMAGE]  = rep_vec[1];
    code[BIT_RECOVERY]     = rep_vec[2];
    code[BIT_TIMER_DAMAGE] = rep_vec[3];
    code[BIT_TIMING_FAC]   = rep_vec[3];
    // storage error kind only rides along with processing damage
    code[BIT_STOR_UNCORR]  = rep_vec[1] && storage_error_uncorrected_flag;
    code[BIT_KEY_UNCORR]   = rep_vec[1] && key_error_uncorrected_flag;
    code[BIT_V_PSW_FIRST +: 4] = SAVE_VALID[3:0];
    code[BIT_V_FADDR]      = fa_valid_reg && rep_vec[1];
    code[BIT_V_FPR]        = SAVE_VALID[4];
    code[BIT_V_GPR]        = SAVE_VALID[5];
    code[BIT_V_CR]         = SAVE_VALID[6];
    code[BIT_V_CPU_TIMER]  = SAVE_VALID[8];
    code[BIT_V_CLK_CMP]    = SAVE_VALID[9];
    code[BIT_V_STORAGE]    = SAVE_VALID[7];
  end

  // copy of the last code for software
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      last_code_reg  <= '0;
      last_faddr_reg <= '0;
    end else if (take) begin
      last_code_reg  <= code;
      last_faddr_reg <= faddr_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fixed-area logout
  mcr_log_if lg ();

  assign lg.start = take;
  assign lg.code  = code;
  assign lg.faddr = faddr_reg;
  // busy is the writer's own state; counting start in would close a loop through take
  assign busy     = lg.busy;

  // code bytes into the fixed area
  mcr_logout u_logout (
    .clk   (CLK_SYS),
    .rst_n (rst_n),
    .lg    (lg.writer)
  );

  // outputs come straight from the writer's flops
  assign ST_WE   = lg.st_we;
  assign ST_ADDR = lg.st_addr;
  assign ST_DATA = lg.st_data;
  assign MC_DONE = lg.done;

  //////////////////////////////////////////////////////////////////////////////
  // service logging
  // follows the operator setting, not the masks
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      DISK_LOG <= 1'b0;
    end else begin
      DISK_LOG <= disk_en && (sd_set || pd_set || sr_set || td_set);
    end
  end
endmodule : mcr_machine_check

// ==== logic/mcr_pkg.sv ====
// shared constants of the machine-check reporting block
package mcr_pkg;
  // code bit positions, numbered from the most significant bit (bit 0)
  localparam int unsigned BIT_SYS_DAMAGE   = 0;
  localparam int unsigned BIT_PROC_DAMAGE  = 1;
  localparam int unsigned BIT_RECOVERY     = 2;
  localparam int unsigned BIT_TIMER_DAMAGE = 3;
  localparam int unsigned BIT_TIMING_FAC   = 4;
  localparam int unsigned BIT_STOR_UNCORR  = 16;
  localparam int unsigned BIT_KEY_UNCORR   = 18;
  localparam int unsigned BIT_V_PSW_FIRST  = 20;
  localparam int unsigned BIT_V_FADDR      = 24;
  localparam int unsigned BIT_V_FPR        = 27;
  localparam int unsigned BIT_V_GPR        = 28;
  localparam int unsigned BIT_V_CR         = 29;
  localparam int unsigned BIT_V_STORAGE    = 31;
  localparam int unsigned BIT_V_CPU_TIMER  = 46;
  localparam int unsigned BIT_V_CLK_CMP    = 47;
  localparam int unsigned CODE_BITS        = 64;
  // fixed logout storage locations
  localparam logic [8:0] LOG_CODE_ADDR  = 9'h0E8; // 232
  localparam logic [8:0] LOG_FADDR_ADDR = 9'h0F8; // 248
  localparam int unsigned CODE_BYTES    = 8;
  localparam int unsigned FADDR_BYTES   = 2;
  localparam int unsigned FADDR_W       = 16;
  localparam int unsigned KEY_BLOCK_LSB = 11;     // 2K block
  // validity input lanes
  localparam int unsigned VIN_W = 10;
  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_CODE_HI = 8'h08;
  localparam logic [7:0] REG_CODE_LO = 8'h0C;
  localparam logic [7:0] REG_FADDR   = 8'h10;
  // control register fields and reset values
  localparam int unsigned CTRL_MCHK_MASK  = 0;
  localparam int unsigned CTRL_RECOV_MASK = 1;
  localparam int unsigned CTRL_EXT_MASK   = 2;
  localparam logic [2:0]  CTRL_RESET      = 3'h4; // only the external damage submask set; bit 13 clear
  // logout sequencer states
  typedef enum logic [0:0] {
    MCR_LOG_IDLE  = 1'b0,
    MCR_LOG_WRITE = 1'b1
  } mcr_log_state_t;
endpackage : mcr_pkg

// ==== logic/mcr_sync.sv ====
`timescale 1ns/1ps
// two-stage synchroniser for levels arriving from outside the clock domain
module mcr_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // level in and out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // refuse a zero-width instance at elaboration
  if (WIDTH < 1) begin : g_bad_width
    $error("mcr_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : mcr_sync

// ==== testbench/mcr_err_model.sv ====
`timescale 1ns/1ps
// error detection and retry hardware: one malfunction pulse set per request
module mcr_err_model (
  // clock
  input  wire logic        clk,
  // requests from the bench
  input  wire logic        go,
  input  wire logic [12:0] ev_mask,
  input  wire logic [15:0] ev_addr,
  // malfunction pulses and failing address toward the block
  output logic      [12:0] ev = 13'h0000,
  output logic      [15:0] addr = 16'h0000
);
  // pulses last one cycle; a released address is inverted every cycle, so a copy taken one cycle late never matches
  always @(posedge clk) begin
    ev   <= go ? ev_mask : 13'h0000;
    addr <= go ? ev_addr : ~addr;
  end
endmodule : mcr_err_model

// ==== testbench/mcr_properties.sv ====
`timescale 1ns/1ps
// watches the port of the machine-check block
module mcr_properties
  import mcr_pkg::*;
(
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST_B,
  // register bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic        WB_ACK_O,
  // events, sequencer and logout
  input wire logic        ERR_SYSTEM,
  input wire logic        ERR_RETRY_OK,
  input wire logic        MC_TAKE,
  input wire logic        MC_REQ,
  input wire logic        MC_DONE,
  input wire logic        ST_WE,
  input wire logic [8:0]  ST_ADDR,
  input wire logic        DISK_LOG_EN,
  input wire logic        DISK_LOG
);
  logic [2:0] ctrl_sh_reg;
  // mask shadow lags the design by one edge, so checks on it are conservative
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_sh_reg <= CTRL_RESET;
    end else if (WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_ADR_I == REG_CTRL
                 && WB_SEL_I[0]) begin
      ctrl_sh_reg <= WB_DAT_I[2:0];
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////////////////////////
  // logout byte stream
  sequence s_code_bytes;
    ST_WE && ST_ADDR == LOG_CODE_ADDR ##1 (ST_WE && ST_ADDR == $past(ST_ADDR) + 9'h001) [*7];
  endsequence
  sequence s_addr_bytes;
    ST_WE && ST_ADDR == LOG_FADDR_ADDR ##1 ST_WE && MC_DONE && ST_ADDR == LOG_FADDR_ADDR + 9'h001;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered next cycle");
  a_masked_quiet: assert property (
    !ctrl_sh_reg[0] && !$past(ctrl_sh_reg[0]) |-> !MC_REQ)
    else $error("request raised with machine-check mask off");
  a_exigent_latency: assert property (
    ERR_SYSTEM && ctrl_sh_reg[0] && $past(ctrl_sh_reg[0]) && !MC_REQ && !ST_WE && !MC_TAKE
    && !$past(MC_TAKE) |-> ##2 MC_REQ)
    else $error("system damage not requested two cycles later");
  a_take_drops: assert property (MC_REQ && MC_TAKE |=> !MC_REQ [*8])
    else $error("request not dropped during logout");
  a_logout_order: assert property (
    MC_REQ && MC_TAKE |-> ##2 s_code_bytes ##1 s_addr_bytes)
    else $error("logout bytes out of order");
  a_done_pulse: assert property (MC_DONE |=> !MC_DONE)
    else $error("done held longer than one cycle");
  a_disk_logs: assert property (DISK_LOG_EN [*4] ##0 ERR_RETRY_OK |=> DISK_LOG)
    else $error("masked event not logged to service");
  a_disk_quiet: assert property (!DISK_LOG_EN [*4] |=> !DISK_LOG)
    else $error("service log pulse while disabled");
endmodule : mcr_properties

bind mcr_machine_check mcr_properties u_props (.CLK_SYS, .RST_B, .WB_CYC_I, .WB_STB_I,
  .WB_WE_I, .WB_ADR_I, .WB_DAT_I, .WB_SEL_I, .WB_ACK_O, .ERR_SYSTEM, .ERR_RETRY_OK,
  .MC_TAKE, .MC_REQ, .MC_DONE, .ST_WE, .ST_ADDR, .DISK_LOG_EN, .DISK_LOG);

// ==== testbench/tb_machine_check_reporting.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_machine_check_reporting;
  import mcr_pkg::*;
  // clock, reset, bus and sequencer
  logic             CLK_SYS = 1'b0, RST_B = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0;
  logic             WB_WE_I = 1'b0, WB_ACK_O, MC_TAKE = 1'b0, MC_REQ, MC_DONE, ST_WE;
  logic             DISK_LOG_EN = 1'b1, DISK_LOG, ev_go = 1'b0;
  logic [7:0]       WB_ADR_I = 8'h00, ST_DATA;
  logic [31:0]      WB_DAT_I = 32'h0, WB_DAT_O, rdat;
  logic [3:0]       WB_SEL_I = 4'h0;
  logic [8:0]       ST_ADDR;
  logic [12:0]      ev, ev_mask = 13'h0000;
  logic [15:0]      ERR_ADDR, ev_addr = 16'h0000;
  logic [VIN_W-1:0] SAVE_VALID = '0;
  logic [7:0]       mem [0:511];
  int               err_count = 0, n_checks = 0, k;

  always #25 CLK_SYS = ~CLK_SYS;
  ////////////////////////////////////////////////////////////////////////////////
  mcr_machine_check DUT (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .ERR_SYSTEM(ev[0]),
    .ERR_INTR_FAIL(ev[1]), .ERR_CREG_DAMAGE(ev[2]), .ERR_UNRETRYABLE(ev[3]),
    .ERR_RETRY_OK(ev[4]), .ERR_RETRY_FAIL(ev[5]), .ERR_TOD_CLOCK(ev[6]),
    .ERR_INTERVAL_TMR(ev[7]), .ERR_CPU_TIMER(ev[8]), .ERR_CLK_CMP(ev[9]),
    .ERR_TIMER_ACCESS(ev[10]), .ERR_KEY_FAIL(ev[11]), .ERR_STOR_MULTI(ev[12]),
    .ERR_ADDR(ERR_ADDR), .SAVE_VALID(SAVE_VALID), .MC_TAKE(MC_TAKE), .MC_REQ(MC_REQ),
    .MC_DONE(MC_DONE), .ST_WE(ST_WE), .ST_ADDR(ST_ADDR), .ST_DATA(ST_DATA),
    .DISK_LOG_EN(DISK_LOG_EN), .DISK_LOG(DISK_LOG));
  mcr_err_model u_err (.clk(CLK_SYS), .go(ev_go), .ev_mask(ev_mask), .ev_addr(ev_addr),
    .ev(ev), .addr(ERR_ADDR));

  // storage as the logout port writes it
  always @(posedge CLK_SYS) begin
    if (ST_WE === 1'b1) mem[ST_ADDR] <= ST_DATA;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // one classic cycle; held until ack is sampled, then released for a cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int i;
    @(posedge CLK_SYS);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= adr;
    WB_DAT_I <= wd;
    WB_SEL_I <= 4'hF;
    for (i = 0; i < 20; i++) begin
      @(posedge CLK_SYS);
      if (WB_ACK_O === 1'b1) break;
    end
    if (i == 20) begin err_count++; final_report(); end
    rdat = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK_SYS);
  endtask : wb

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    `CHK(rdat, exp)
  endtask : rd_chk

  // ask the error model for one set of simultaneous pulses
  task automatic fire(input logic [12:0] m, input logic [15:0] a);
    @(posedge CLK_SYS);
    ev_mask <= m;
    ev_addr <= a;
    ev_go   <= 1'b1;
    @(posedge CLK_SYS);
    ev_go <= 1'b0;
  endtask : fire

  // acts as the interruption sequencer, then checks logged bytes and code registers
  task automatic take(input logic [31:0] hi, input logic [31:0] lo, input logic [15:0] fa);
    int i;
    for (i = 232; i < 250; i++) mem[i] = 8'hxx;
    for (i = 0; i < 20; i++) begin
      @(negedge CLK_SYS);
      if (MC_REQ === 1'b1) break;
    end
    if (i == 20) begin err_count++; final_report(); end
    @(posedge CLK_SYS);
    MC_TAKE <= 1'b1;
    @(posedge CLK_SYS);
    MC_TAKE <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(negedge CLK_SYS);
      if (MC_DONE === 1'b1) break;
    end
    if (i == 20) begin err_count++; final_report(); end
    @(negedge CLK_SYS);
    `CHK({mem[232], mem[233], mem[234], mem[235]}, hi)
    `CHK({mem[236], mem[237], mem[238], mem[239]}, lo)
    if (hi[7]) `CHK({mem[248], mem[249]}, fa)
    rd_chk(REG_CODE_HI, hi);
    rd_chk(REG_CODE_LO, lo);
  endtask : take
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    rd_chk(REG_CTRL, 32'h4);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    rd_chk(8'h20, 32'h0);
    rd_chk(REG_STATUS, 32'h0);
    // held off while the status-word mask bit is clear
    wb(1'b1, REG_CTRL, 32'h6);
    fire(13'h0001, 16'h0000);
    repeat (6) @(posedge CLK_SYS);
    `CHK(MC_REQ, 1'b0)
    rd_chk(REG_STATUS, 32'h1);
    wb(1'b1, REG_CTRL, 32'h7);
    take(32'h8000_0000, 32'h0, 16'h0);
    // storage error with every save area valid, then key error with none valid
    SAVE_VALID <= '1;
    fire(13'h1020, 16'hA5C3);
    take(32'h4000_8F9D, 32'h0003_0000, 16'hA5C3);
    SAVE_VALID <= '0;
    fire(13'h0808, 16'hA5C3);
    take(32'h4000_2080, 32'h0, 16'hA000);
    // recovery report waits for its submask
    wb(1'b1, REG_CTRL, 32'h5);
    fire(13'h0010, 16'h0000);
    repeat (2) @(negedge CLK_SYS);
    `CHK(DISK_LOG, 1'b1)
    repeat (6) @(posedge CLK_SYS);
    `CHK(MC_REQ, 1'b0)
    wb(1'b1, REG_CTRL, 32'h7);
    take(32'h2000_0000, 32'h0, 16'h0);
    // timing damage waits for the external submask
    wb(1'b1, REG_CTRL, 32'h3);
    fire(13'h0040, 16'h0000);
    repeat (6) @(posedge CLK_SYS);
    `CHK(MC_REQ, 1'b0)
    wb(1'b1, REG_CTRL, 32'h7);
    take(32'h1800_0000, 32'h0, 16'h0);
    for (k = 7; k < 10; k++) begin
      fire(13'(1 << k), 16'h0000);
      take(32'h1800_0000, 32'h0, 16'h0);
    end
    fire(13'h0400, 16'h0000);
    take(32'h5800_0000, 32'h0, 16'h0);
    // system damage sources with both submasks off and service logging disabled
    DISK_LOG_EN <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h1);
    repeat (5) @(posedge CLK_SYS);
    for (k = 0; k < 3; k++) begin
      fire(13'(1 << k), 16'h0000);
      repeat (2) @(negedge CLK_SYS);
      `CHK(DISK_LOG, 1'b0)
      take(32'h8000_0000, 32'h0, 16'h0);
    end
    DISK_LOG_EN <= 1'b1;
    final_report();
  end
endmodule : tb_machine_check_reporting
